// file: logic/tws_cfg.svh
// Purpose: Constants shared by both ends of the two-wire slave front end
// Assumes: Included by its bare name; definitions only
// Notes:   Offsets are byte addresses on the controller's APB port
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// Address byte decoding
`define TWS_DEV_TYPE       4'ha
`define TWS_SEL_EEPROM     3'h0
`define TWS_SEL_CSR        3'h2
`define TWS_SEL_POT        3'h7
`define TWS_BITS_PER_BYTE  4'h8

// Timing
`define TWS_CLK_PERIOD_NS  25
`define TWS_SCL_PERIOD_NS  10000
`define TWS_QTR_CYC        ((`TWS_SCL_PERIOD_NS / 4) / `TWS_CLK_PERIOD_NS)

// Controller register offsets
`define TWS_REG_CMD        12'h000
`define TWS_REG_TXD        12'h004
`define TWS_REG_STAT       12'h008
`define TWS_REG_PERMIT     12'h00c

// Command register fields
`define TWS_CMD_START      0
`define TWS_CMD_STOP       1
`define TWS_CMD_READ       2
`define TWS_CMD_NACK       3

// Status register fields
`define TWS_STAT_BUSY      0
`define TWS_STAT_ACK       1
`define TWS_STAT_REFUSED   2
`define TWS_STAT_RXD_LSB   8

`endif

// file: logic/tws_pkg.sv
// Purpose: Types shared by both ends of the two-wire slave front end
// Assumes: Nothing
// Notes:   All state of each end is one packed struct
package tws_pkg;

   // Device end states
   typedef enum logic [2:0] {
      D_IDLE   = 3'h0,
      D_ADDR   = 3'h1,
      D_AACK   = 3'h2,
      D_WBYTE  = 3'h3,
      D_WACK   = 3'h4,
      D_RBYTE  = 3'h5,
      D_RACK   = 3'h6,
      D_IGNORE = 3'h7
   } tws_dev_st_e;

   // Controller states
   typedef enum logic [1:0] {
      H_IDLE  = 2'h0,
      H_START = 2'h1,
      H_BIT   = 2'h2,
      H_STOP  = 2'h3
   } tws_host_st_e;

   // Device end state
   typedef struct packed {
      logic        scl_s1;
      logic        scl_s2;
      logic        sda_s1;
      logic        sda_s2;
      logic        scl_q;
      logic        sda_q;
      tws_dev_st_e st;
      logic [3:0]  cnt;
      logic [7:0]  shf;
      logic [2:0]  tgt;
      logic        rd_dir;
      logic        sel_valid;
      logic        mack;
      logic        sda_oe;
      logic [7:0]  wr_data;
      logic        wr_valid;
      logic        rd_take;
      logic        standby;
   } tws_dev_s;

   // Controller state
   typedef struct packed {
      logic         sda_s1;
      logic         sda_s2;
      tws_host_st_e st;
      logic [1:0]   q;
      logic [11:0]  div;
      logic [3:0]   bitn;
      logic         stop;
      logic         rd;
      logic         nack;
      logic [7:0]   tx;
      logic [7:0]   rx;
      logic         ack;
      logic         refused;
      logic         permit;
      logic         scl_oe;
      logic         sda_oe;
      logic [31:0]  prdata;
   } tws_host_s;

endpackage

// file: logic/tws_bus_if.sv
// Purpose: Open-drain two-wire bus joining controller and device
// Assumes: Pull-ups on both lines; a line is low while any party enables
// Notes:   Wire levels are resolved here from the enables
`timescale 1ns/100ps
interface tws_bus_if;
   logic scl_m_out;  // Controller clock drive value
   logic scl_m_oe;   // Controller clock drive enable
   logic sda_m_out;  // Controller data drive value
   logic sda_m_oe;   // Controller data drive enable
   logic sda_s_out;  // Device data drive value
   logic sda_s_oe;   // Device data drive enable
   logic scl;        // Resolved clock level
   logic sda;        // Resolved data level

   // Wired-AND with pull-up
   assign scl = !(scl_m_oe && !scl_m_out);
   assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));

   modport master (output scl_m_out, scl_m_oe, sda_m_out, sda_m_oe, input scl, sda);
   modport slave  (output sda_s_out, sda_s_oe, input scl, sda);
endinterface

// file: logic/tws_dev.sv
// Purpose: Device end: START/STOP detect, ack handshake, address decode
// Assumes: Bus lines are asynchronous; sampled by two flops each
// Notes:   Byte contents are handed to and taken from the user side
`timescale 1ns/100ps
`include "tws_cfg.svh"
module tws_dev (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Two-wire bus
   tws_bus_if.slave         bus,
   // Read data source
   input  wire logic [7:0]  rd_data_i,
   output logic             rd_take_o,
   // Received bytes
   output logic [7:0]       wr_data_o,
   output logic             wr_valid_o,
   // Write permission
   input  wire logic        write_permit_i,
   output logic             write_ok_o,
   // Selection status
   output logic [2:0]       target_o,
   output logic             read_dir_o,
   output logic             sel_valid_o,
   output logic             standby_o
);
   import tws_pkg::*;

   tws_pkg::tws_dev_s r;      // Registered state
   tws_pkg::tws_dev_s n;      // Next state
   logic       scl_rise;      // Synced clock rose
   logic       scl_fall;      // Synced clock fell
   logic       start_det;     // START seen
   logic       stop_det;      // STOP seen
   logic       type_ok;       // Type field matches
   logic       sel_ok;        // Select code is defined
   logic       last_bit;      // Eight bits clocked

   // Edge and condition detection on synced lines only
   assign scl_rise  = r.scl_s2 && !r.scl_q;
   assign scl_fall  = !r.scl_s2 && r.scl_q;
   // High-to-low data with clock high
   assign start_det = r.scl_s2 && r.scl_q && r.sda_q && !r.sda_s2;
   // Low-to-high data with clock high
   assign stop_det  = r.scl_s2 && r.scl_q && !r.sda_q && r.sda_s2;
   assign last_bit  = (r.cnt == `TWS_BITS_PER_BYTE);

   // Address byte decode
   assign type_ok = (r.shf[7:4] == `TWS_DEV_TYPE);
   assign sel_ok  = (r.shf[3:1] == `TWS_SEL_EEPROM) ||
                    (r.shf[3:1] == `TWS_SEL_CSR) ||
                    (r.shf[3:1] == `TWS_SEL_POT);

   // Next-state logic
   always_comb begin
      n = r;
      // Two-flop synchronisers, then edge history
      n.scl_s1   = bus.scl;
      n.scl_s2   = r.scl_s1;
      n.sda_s1   = bus.sda;
      n.sda_s2   = r.sda_s1;
      n.scl_q    = r.scl_s2;
      n.sda_q    = r.sda_s2;
      // Pulses last one cycle
      n.wr_valid = 1'b0;
      n.rd_take  = 1'b0;
      if (start_det) begin
         // Any START, also repeated, restarts address reception
         n.st        = D_ADDR;
         n.cnt       = 4'h0;
         n.sda_oe    = 1'b0;
         n.standby   = 1'b0;
         n.sel_valid = 1'b0;
      end else if (stop_det) begin
         // Standby only after a read sequence
         if (r.sel_valid && r.rd_dir) begin
            n.standby = 1'b1;
         end
         n.st        = D_IDLE;
         n.sda_oe    = 1'b0;
         n.sel_valid = 1'b0;
      end else begin
         case (r.st)
            // Idle or unselected: driver stays released
            D_IDLE, D_IGNORE: begin
               n.sda_oe = 1'b0;
            end
            // Address byte, MSB first
            D_ADDR: begin
               if (scl_rise && !last_bit) begin
                  n.shf = {r.shf[6:0], r.sda_s2};
                  n.cnt = r.cnt + 4'h1;
               end else if (scl_fall && last_bit) begin
                  if (type_ok && sel_ok) begin
                     // Ack only a valid identifier and select
                     n.sda_oe    = 1'b1;
                     n.tgt       = r.shf[3:1];
                     n.rd_dir    = r.shf[0];
                     n.sel_valid = 1'b1;
                     n.st        = D_AACK;
                  end else begin
                     // No ack; wait for next START
                     n.st = D_IGNORE;
                  end
               end
            end
            // Address ack: held to end of ninth clock, then released for a write or first read bit driven
            D_AACK: begin
               if (scl_fall) begin
                  n.cnt = 4'h0;
                  if (r.rd_dir) begin
                     // First read byte goes out while clock is low
                     n.shf     = rd_data_i;
                     n.rd_take = 1'b1;
                     n.sda_oe  = !rd_data_i[7];
                     n.st      = D_RBYTE;
                  end else begin
                     n.sda_oe = 1'b0;
                     n.st     = D_WBYTE;
                  end
               end
            end
            // Receive a write byte
            D_WBYTE: begin
               if (scl_rise && !last_bit) begin
                  n.shf = {r.shf[6:0], r.sda_s2};
                  n.cnt = r.cnt + 4'h1;
               end else if (scl_fall && last_bit) begin
                  n.wr_data  = r.shf;
                  n.wr_valid = 1'b1;
                  n.sda_oe   = 1'b1;
                  n.st       = D_WACK;
               end
            end
            // Write ack held through ninth clock
            D_WACK: begin
               if (scl_fall) begin
                  n.sda_oe = 1'b0;
                  n.cnt    = 4'h0;
                  n.st     = D_WBYTE;
               end
            end
            // Transmit a read byte
            D_RBYTE: begin
               if (scl_rise) begin
                  n.cnt = r.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (last_bit) begin
                     // Release for master's ack
                     n.sda_oe = 1'b0;
                     n.st     = D_RACK;
                  end else begin
                     // Next bit only while clock is low
                     n.shf    = {r.shf[6:0], 1'b0};
                     n.sda_oe = !r.shf[6];
                  end
               end
            end
            // Sample master ack on ninth clock
            D_RACK: begin
               if (scl_rise) begin
                  n.mack = !r.sda_s2;
               end else if (scl_fall) begin
                  if (r.mack) begin
                     // Acked and no STOP: next byte
                     n.shf     = rd_data_i;
                     n.rd_take = 1'b1;
                     n.sda_oe  = !rd_data_i[7];
                     n.cnt     = 4'h0;
                     n.st      = D_RBYTE;
                  end else begin
                     // No ack: stay released until STOP or START
                     n.sda_oe = 1'b0;
                     n.st     = D_IGNORE;
                  end
               end
            end
            default: begin
               n.st     = D_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // State register; released driver after reset
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Open-drain data: value always low, enable selects
   assign bus.sda_s_out = 1'b0;
   assign bus.sda_s_oe  = r.sda_oe;

   // User-side outputs
   assign rd_take_o   = r.rd_take;
   assign wr_data_o   = r.wr_data;
   assign wr_valid_o  = r.wr_valid;
   // Array and pot writes need the permit latch; register writes do not
   assign write_ok_o  = r.sel_valid && !r.rd_dir &&
                        (write_permit_i || (r.tgt == `TWS_SEL_CSR));
   assign target_o    = r.tgt;
   assign read_dir_o  = r.rd_dir;
   assign sel_valid_o = r.sel_valid;
   assign standby_o   = r.standby;

endmodule

// file: logic/tws_host.sv
// Purpose: Bus master end: byte-level controller driven over APB
// Assumes: Device answers within the first low quarter after the clock falls
// Notes:   Clock is divided from clk_i; zero-wait APB slave
`timescale 1ns/100ps
`include "tws_cfg.svh"
module tws_host #(
   parameter int QTR_CYC = `TWS_QTR_CYC  // Cycles per quarter bit
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Two-wire bus
   tws_bus_if.master        bus
);
   import tws_pkg::*;

   // Elaboration check: 12-bit divider, and a quarter must outlast the device's sync delay
   if (QTR_CYC < 8 || QTR_CYC > 4095) begin : g_qtr_chk
      $error("QTR_CYC out of range");
   end

   tws_pkg::tws_host_s r;   // Registered state
   tws_pkg::tws_host_s n;   // Next state
   logic tick;              // Quarter-bit boundary
   logic wr_acc;            // APB write access
   logic mapped;            // Address decodes
   logic tgt_gated;         // Target needs permit

   assign tick    = (r.div == 12'(QTR_CYC - 1));
   assign wr_acc  = psel && penable && pwrite;
   assign mapped  = (paddr == `TWS_REG_CMD) || (paddr == `TWS_REG_TXD) ||
                    (paddr == `TWS_REG_STAT) || (paddr == `TWS_REG_PERMIT);
   assign tgt_gated = !r.tx[0] && ((r.tx[3:1] == `TWS_SEL_EEPROM) ||
                                   (r.tx[3:1] == `TWS_SEL_POT));

   // Next-state logic
   always_comb begin
      n = r;
      n.sda_s1 = bus.sda;
      n.sda_s2 = r.sda_s1;
      n.div    = tick ? 12'h000 : r.div + 12'h001;
      // Read data captured in setup phase
      if (psel && !penable) begin
         case (paddr)
            `TWS_REG_TXD:    n.prdata = {24'h000000, r.tx};
            `TWS_REG_STAT:   n.prdata = {16'h0000, r.rx, 5'h00, r.refused, r.ack,
                                         (r.st != H_IDLE)};
            `TWS_REG_PERMIT: n.prdata = {31'h00000000, r.permit};
            default:         n.prdata = 32'h00000000;
         endcase
      end
      // Register writes; busy controller ignores commands
      if (wr_acc && paddr == `TWS_REG_CMD) begin
         if (r.st != H_IDLE) begin
            n.refused = 1'b1;
         end else if (pwdata[`TWS_CMD_START] && tgt_gated && !r.permit) begin
            // Array or pot write refused until latch is set
            n.refused = 1'b1;
         end else begin
            n.refused = 1'b0;
            n.stop    = pwdata[`TWS_CMD_STOP];
            n.rd      = pwdata[`TWS_CMD_READ];
            n.nack    = pwdata[`TWS_CMD_NACK];
            n.bitn    = 4'h0;
            n.q       = 2'h0;
            n.div     = 12'h000;
            // Address byte follows START directly
            n.st      = pwdata[`TWS_CMD_START] ? H_START : H_BIT;
         end
      end else if (wr_acc && paddr == `TWS_REG_TXD && r.st == H_IDLE) begin
         n.tx = pwdata[7:0];
      end else if (wr_acc && paddr == `TWS_REG_PERMIT) begin
         n.permit = pwdata[0];
      end
      // Bit engine, one step per quarter
      if (tick && r.st != H_IDLE) begin
         n.q = r.q + 2'h1;
         case (r.st)
            // Clock high, then data falls: START
            H_START: begin
               case (r.q)
                  2'h0:    n.sda_oe = 1'b0;
                  2'h1:    n.scl_oe = 1'b0;
                  2'h2:    n.sda_oe = 1'b1;
                  default: begin
                     n.scl_oe = 1'b1;
                     n.st     = H_BIT;
                  end
               endcase
            end
            // Eight data bits then the ack bit
            H_BIT: begin
               case (r.q)
                  2'h0: begin
                     n.scl_oe = 1'b1;
                     // Data changes only with clock low
                     if (r.bitn < 4'h8) begin
                        n.sda_oe = !r.rd && !r.tx[7];
                     end else begin
                        n.sda_oe = r.rd && !r.nack;
                     end
                  end
                  2'h1:    n.scl_oe = 1'b1;
                  2'h2:    n.scl_oe = 1'b0;
                  default: begin
                     if (r.bitn < 4'h8) begin
                        n.rx = {r.rx[6:0], r.sda_s2};
                        n.tx = {r.tx[6:0], 1'b0};
                     end else begin
                        n.ack = !r.sda_s2;
                     end
                     n.bitn   = r.bitn + 4'h1;
                     n.scl_oe = 1'b1;
                     if (r.bitn == 4'h8) begin
                        // Withheld read ack is always closed by STOP
                        n.st = (r.stop || (r.rd && r.nack)) ? H_STOP : H_IDLE;
                     end
                  end
               endcase
            end
            // Data low under low clock, clock high, data rises
            H_STOP: begin
               case (r.q)
                  2'h0:    n.sda_oe = 1'b1;
                  2'h1:    n.sda_oe = 1'b1;
                  2'h2:    n.scl_oe = 1'b0;
                  default: begin
                     n.sda_oe = 1'b0;
                     n.st     = H_IDLE;
                  end
               endcase
            end
            default: n.st = H_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Open-drain drive and APB answers
   assign bus.scl_m_out = 1'b0;
   assign bus.scl_m_oe  = r.scl_oe;
   assign bus.sda_m_out = 1'b0;
   assign bus.sda_m_oe  = r.sda_oe;
   assign pready        = 1'b1;
   assign prdata        = r.prdata;
   assign pslverr       = psel && penable && !mapped;

endmodule

// file: tb/tws_sva.sv
// Purpose: Wire-level checks of the device end of the two-wire link
// Assumes: Lines resolved in the interface; one clock domain
// Notes:   Bit position and address outcome are tracked from the wires
`timescale 1ns/100ps
module tws_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Bus drive signals and resolved lines
   input wire logic scl_m_out,
   input wire logic scl_m_oe,
   input wire logic sda_m_out,
   input wire logic sda_m_oe,
   input wire logic sda_s_out,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_r, sda_r;    // Previous line levels
   logic [3:0] nbit_r;          // Clock rises since START or since the last ninth rise
   logic [7:0] shf_r;           // Bits seen at rises
   logic       first_r, seen_r; // Address byte pending, START seen
   logic       wsel_r, rsel_r;  // Selected for write or read
   logic       bad_r, nak_r;    // Bad address, read not acked
   logic       strt, stp, rise, ninth, good;

   // Line events and address decode
   assign strt  = scl && scl_r && sda_r && !sda;
   assign stp   = scl && scl_r && !sda_r && sda;
   assign rise  = scl && !scl_r;
   assign ninth = rise && (nbit_r == 4'h8);
   assign good  = (shf_r[7:4] == 4'ha) &&
                  (shf_r[3:1] == 3'h0 || shf_r[3:1] == 3'h2 || shf_r[3:1] == 3'h7);

   // Follow framing from the wires alone
   always_ff @(posedge clk_i) begin
      scl_r <= scl;
      sda_r <= sda;
      shf_r <= (rise && !ninth) ? {shf_r[6:0], sda} : shf_r;
      if (reset_i) begin
         nbit_r  <= 4'h0;
         seen_r  <= 1'b0;
         first_r <= 1'b0;
         wsel_r  <= 1'b0;
         rsel_r  <= 1'b0;
         bad_r   <= 1'b0;
         nak_r   <= 1'b0;
      end else if (strt || stp) begin
         nbit_r  <= 4'h0;
         seen_r  <= seen_r || strt;
         first_r <= strt;
         wsel_r  <= 1'b0;
         rsel_r  <= 1'b0;
         bad_r   <= 1'b0;
         nak_r   <= 1'b0;
      end else if (rise) begin
         nbit_r <= ninth ? 4'h0 : nbit_r + 4'h1;
         nak_r  <= nak_r || (ninth && rsel_r && sda);
         if (ninth && first_r) begin
            first_r <= 1'b0;
            wsel_r  <= good && !shf_r[0];
            rsel_r  <= good && shf_r[0];
            bad_r   <= !good;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   dev_reset_rel_a: assert property ($fell(reset_i) |-> !sda_s_oe [*3])
      else $error("device drives data right after reset");
   dev_scl_low_a: assert property ($changed(sda_s_oe) |-> !scl)
      else $error("device data drive changed while clock high");
   no_start_quiet_a: assert property (!seen_r |-> !sda_s_oe)
      else $error("device drove data before any start");
   addr_ack_a: assert property (ninth && first_r |-> (sda == !good))
      else $error("address acknowledge does not match decode");
   write_ack_a: assert property (ninth && wsel_r |-> sda_s_oe && !sda)
      else $error("written byte not acknowledged");
   read_release_a: assert property (ninth && rsel_r |-> !sda_s_oe)
      else $error("device holds data line in read acknowledge slot");
   nack_quiet_a: assert property (nak_r |-> !sda_s_oe)
      else $error("device drives after read byte not acknowledged");
   bad_addr_quiet_a: assert property (bad_r |-> !sda_s_oe)
      else $error("device drives after unmatched address");
endmodule

// file: tb/two_wire_slave_front_end_tb.sv
// Purpose: Self-checking run of controller and device joined on one bus
// Assumes: Controller quarter bit shortened to 8 cycles
// Notes:   Expected written and taken read bytes are queued, then matched on receipt or status read
`timescale 1ns/100ps
`include "tws_cfg.svh"
module two_wire_slave_front_end_tb;
   localparam logic [31:0] C_S = 32'h1 << `TWS_CMD_START; // Start before byte
   localparam logic [31:0] C_P = 32'h1 << `TWS_CMD_STOP;  // Stop after byte
   localparam logic [31:0] C_R = 32'h1 << `TWS_CMD_READ;  // Read a byte
   localparam logic [31:0] C_N = 32'h1 << `TWS_CMD_NACK;  // Withhold ack
   logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, st;
   logic [7:0]  rd_data_i, wr_data_o, d;
   logic [2:0]  target_o, t;
   logic        write_permit_i, rd_take_o, wr_valid_o, write_ok_o;
   logic        read_dir_o, sel_valid_o, standby_o;
   int          n_mismatch, checked, seed;
   logic [7:0]  wq[$], rq[$];  // Expected written bytes, taken read bytes

   tws_bus_if bus_if ();
   tws_host #(.QTR_CYC(8)) i_tws_host (.clk_i, .reset_i, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .bus(bus_if.master));
   tws_dev i_tws_dev (.clk_i, .reset_i, .bus(bus_if.slave), .rd_data_i, .rd_take_o,
      .wr_data_o, .wr_valid_o, .write_permit_i, .write_ok_o, .target_o, .read_dir_o,
      .sel_valid_o, .standby_o);
   tws_sva i_tws_sva (.clk_i, .reset_i, .scl_m_out(bus_if.scl_m_out),
      .scl_m_oe(bus_if.scl_m_oe), .sda_m_out(bus_if.sda_m_out), .sda_m_oe(bus_if.sda_m_oe),
      .sda_s_out(bus_if.sda_s_out), .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl),
      .sda(bus_if.sda));

   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
      end
   endtask

   task automatic close_out();
      $display("Counts: %0d compared, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // A wait ran out of its bound
   task automatic tmo(input string what);
      n_mismatch++;
      $display("[ERR] %0t timeout: %s", $time, what);
      close_out();
   endtask

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int i;
      @(posedge clk_i);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk_i);
         if (pready === 1'b1) break;
      end
      if (i == 16) tmo("apb");
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Load byte and command, then poll status until idle
   task automatic xfer(input logic [31:0] cmd, input logic [7:0] tx, output logic [31:0] s);
      int i;
      apb(1'b1, `TWS_REG_TXD, {24'h0, tx}, s);
      apb(1'b1, `TWS_REG_CMD, cmd, s);
      for (i = 0; i < 1000; i++) begin
         apb(1'b0, `TWS_REG_STAT, 32'h0, s);
         if (s[`TWS_STAT_BUSY] === 1'b0) break;
      end
      if (i == 1000) tmo("busy");
   endtask

   // Selection outputs packed for one compare
   function automatic logic [31:0] sel();
      return {25'h0, standby_o, write_ok_o, sel_valid_o, read_dir_o, target_o};
   endfunction

   // Give the device a fresh byte at each take and note the one taken
   always @(posedge clk_i) begin
      if (rd_take_o === 1'b1) begin
         rq.push_back(rd_data_i);
         rd_data_i <= 8'($random(seed));
      end
   end

   // Match each received byte against the oldest note
   always @(posedge clk_i) begin
      if (wr_valid_o === 1'b1) begin
         if (wq.size() == 0) chk(32'(wr_valid_o), 32'h0, "unexpected byte");
         else chk(32'(wr_data_o), 32'(wq.pop_front()), "received byte");
      end
   end

   initial begin
      seed = 32'hb4a7;
      n_mismatch = 0;
      checked = 0;
      reset_i = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      rd_data_i = 8'h3c;
      write_permit_i = 1'b0;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(32'({bus_if.sda_s_oe, bus_if.scl, bus_if.sda}), 32'h3, "idle lines");
      // Reads of two bytes from each target, second one not acknowledged
      for (int k = 0; k < 3; k++) begin
         t = (k == 0) ? 3'h0 : (k == 1) ? 3'h2 : 3'h7;
         xfer(C_S, {4'ha, t, 1'b1}, st);
         chk(32'(st[`TWS_STAT_ACK]), 32'h1, "read address ack");
         chk(sel(), {25'h0, 4'h3, t}, "read select");
         xfer(C_R, 8'h0, st);
         chk(32'(st[15:8]), 32'(rq.pop_front()), "first read byte");
         xfer(C_R | C_N | C_P, 8'h0, st);
         chk(32'(st[15:8]), 32'(rq.pop_front()), "last read byte");
         // Device sees STOP a few cycles after the controller reports idle
         repeat (4) @(posedge clk_i);
         chk(32'({standby_o, sel_valid_o}), 32'h2, "standby after read");
      end
      // Writes with permit off then on; register target needs none
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, `TWS_REG_PERMIT, 32'(p), st);
         write_permit_i <= p[0];
         for (int k = 0; k < 3; k++) begin
            t = (k == 0) ? 3'h0 : (k == 1) ? 3'h2 : 3'h7;
            xfer(C_S, {4'ha, t, 1'b0}, st);
            chk(32'(st[`TWS_STAT_REFUSED]), 32'(p == 0 && t != 3'h2), "refusal");
            if (p == 1 || t == 3'h2) begin
               chk(32'(st[`TWS_STAT_ACK]), 32'h1, "write address ack");
               chk(sel(), {25'h0, 4'h6, t}, "write select");
               for (int b = 0; b < 2; b++) begin
                  d = 8'($random(seed));
                  wq.push_back(d);
                  xfer((b == 1) ? C_P : 32'h0, d, st);
                  chk(32'(st[`TWS_STAT_ACK]), 32'h1, "data ack");
               end
               repeat (4) @(posedge clk_i);
               chk(32'(sel_valid_o), 32'h0, "deselect after stop");
            end
         end
      end
      // Unmatched addresses: no ack, following byte ignored
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 8'hb4 : (k == 1) ? 8'ha2 : 8'ha9;
         xfer(C_S, d, st);
         chk(32'(st[`TWS_STAT_ACK]), 32'h0, "bad address ack");
         chk(32'(sel_valid_o), 32'h0, "bad address select");
         xfer(C_P, 8'($random(seed)), st);
         chk(32'(st[`TWS_STAT_ACK]), 32'h0, "ignored byte ack");
      end
      // Unmapped register place
      apb(1'b0, 12'h010, 32'h0, st);
      chk({31'h0, err}, 32'h1, "unmapped error");
      chk(st, 32'h0, "unmapped data");
      chk(32'(wq.size()), 32'h0, "bytes not received");
      close_out();
   end
endmodule
